// file: core/led_sup_pkg.sv
package led_sup_pkg;

  // ----------------------------------------------------------------
  // geometry and timing
  // ----------------------------------------------------------------
  localparam int          NUM_STRINGS   = 8;
  localparam int          CLK_HZ        = 20_000_000;
  localparam int          DIAG_PHASE_NS = 1_024_000;
  localparam int          SOFT_START_NS = 4_200_000;
  localparam int          STARTUP_MAX_NS = 10_000_000;
  localparam int          BLANK_NS      = 24_000;
  localparam int          SHORT_HOLD_NS = 2_000_000;
  localparam int          OC_TIMER_NS   = 128_000;
  localparam int          GATE_MAX_NS   = 15_000;
  localparam int          CLK_NS        = 1_000_000_000 / CLK_HZ;
  localparam int          DIAG_CYC      = DIAG_PHASE_NS / CLK_NS;
  localparam int          SOFT_CYC      = SOFT_START_NS / CLK_NS;
  localparam int          STARTUP_CYC   = STARTUP_MAX_NS / CLK_NS;
  localparam int          BLANK_CYC     = (BLANK_NS + CLK_NS - 1) / CLK_NS;
  localparam int          SHORT_CYC     = SHORT_HOLD_NS / CLK_NS + 1;
  localparam int          OC_CYC        = OC_TIMER_NS / CLK_NS;
  localparam int          GATE_CYC      = GATE_MAX_NS / CLK_NS;

  // ----------------------------------------------------------------
  // register map (word aligned byte addresses)
  // ----------------------------------------------------------------
  localparam logic [3:0]  ADDR_CONTROL  = 4'h4;
  localparam logic [3:0]  ADDR_STATUS   = 4'h8;
  localparam logic [3:0]  ADDR_STRINGS  = 4'hC;
  localparam int          CTRL_EN_BIT   = 0;
  localparam int          STAT_OPEN_BIT = 4;
  localparam int          STAT_SHORT_BIT = 5;
  localparam int          STAT_OC_BIT   = 6;
  localparam int          STAT_GND_BIT  = 7;
  localparam int          STAT_DIODE_BIT = 3;
  localparam logic [7:0]  CONTROL_RST   = 8'h00;
  localparam logic [7:0]  STATUS_RST    = 8'h00;

  // ----------------------------------------------------------------
  // types
  // ----------------------------------------------------------------
  typedef enum logic [2:0] {
    ST_RESET    = 3'b000,
    ST_DIODE    = 3'b001,
    ST_DIAG1    = 3'b011,
    ST_DIAG2    = 3'b010,
    ST_SOFT     = 3'b110,
    ST_RUN      = 3'b111,
    ST_SHUTDOWN = 3'b101
  } seq_state_t;

  typedef enum logic [1:0] {
    FREQ_500K  = 2'b00,
    FREQ_750K  = 2'b01,
    FREQ_1000K = 2'b10
  } freq_sel_t;

  typedef struct packed {
    logic       supply_good;
    logic       uvlo_ok;
    logic       ov_above;
    logic       ov_diode_low;
    logic       current_limit;
    logic [7:0] fb_above_short;
    logic [7:0] fb_above_unused;
    logic [7:0] fb_below_gnd;
    logic [7:0] fb_below_open;
  } comp_t;

  typedef struct packed {
    logic       regulator_en;
    logic       boost_en;
    logic       switch_en;
    logic       soft_start;
    logic       diag_discharge;
    logic       diag_precharge;
    logic [7:0] source_on;
    logic [7:0] lvc_select;
  } analog_ctl_t;

endpackage : led_sup_pkg

// file: core/led_string_startup_fault_supervisor.sv
`timescale 1ns/1ps
// Notes on behaviour
// - supply-good rising clears the fault latch and loads registers with reset values
// - converter stays disabled until undervoltage lockout reports supply above threshold
// - startup samples diode check first; low overvoltage sense blocks the boost start
// - diode pass leads to two diagnostic phases, each timed by the clock
// - phase one: string still above upper threshold is marked shorted and excluded
// - phase one: non-shorted string above unused threshold is unused, source off
// - phase two: any enabled node below low threshold disables the whole device
// - after diagnostics, soft-start runs; whole startup bounded by ten milliseconds
// - host clears enable bit for shutdown, sets it to restart
// - critical failure enters shutdown and turns off regulator, boost, switch, soft-start, diagnostics and string sources
// - status register survives shutdown, cleared when a new startup begins or supply-good rises
// - tri-level pin selects 500, 750 or 1000 kHz switching
// - overvoltage comparator high holds power switch off until it releases
// - string sources follow gate commands within fifteen microseconds
// - string enables captured at power-up scan and in diagnostic phase one, ties during run ignored
// - lowest level taken only among enabled strings for the error amplifier
// - post-start open or short disables only that string, sets status bits four/five
// - string below open threshold gets its current source disabled
// - all enabled strings open shuts down the boost converter
// - short ignored 24 us after switch-on, string disabled after 2 ms persistence
// - short detection suppressed for the whole soft-start interval
// - all enabled sources gated together by the internal dimming pwm
// - current limit lasting the 128 us timer is a critical shutdown
module led_string_startup_fault_supervisor
  import led_sup_pkg::*;
#(
  parameter int STARTUP_LIMIT = STARTUP_CYC,
  parameter int SHORT_LIMIT   = SHORT_CYC,
  parameter int DIAG_LIMIT    = DIAG_CYC,
  parameter int SOFT_LIMIT    = SOFT_CYC
) (
  // clock and reset
  input  wire logic                 clk_sys,
  input  wire logic                 srst,
  input  wire logic                 clk_en,
  // avalon-mm slave
  input  wire logic [3:0]           avs_address,
  input  wire logic                 avs_read,
  input  wire logic                 avs_write,
  input  wire logic [31:0]          avs_writedata,
  input  wire logic [3:0]           avs_byteenable,
  output logic      [31:0]          avs_readdata,
  output logic                      avs_waitrequest,
  // analog comparators, raw
  input  wire led_sup_pkg::comp_t   comp_raw,
  // tri-level frequency pin, decoded as low and high sense
  input  wire logic                 switch_frequency_select_pin_low,
  input  wire logic                 switch_frequency_select_pin_high,
  // dimming
  input  wire logic                 internal_dimming_pwm,
  // analog controls
  output led_sup_pkg::analog_ctl_t  analog_ctl,
  output led_sup_pkg::freq_sel_t    switch_freq,
  output led_sup_pkg::seq_state_t   seq_state
);
  import led_sup_pkg::*;

  // ----------------------------------------------------------------
  // state
  // ----------------------------------------------------------------
  typedef struct packed {
    comp_t       sync1;
    comp_t       sync2;
    logic        pwm_s1;
    logic        pwm_s2;
    logic        good_prev;
    logic        scanned;
    logic [7:0]  tied_off;
    logic [7:0]  control;
    logic [7:0]  status;
    logic [7:0]  excluded;
    logic [7:0]  short_seen;
    logic [7:0]  open_seen;
    seq_state_t  st;
    logic [23:0] phase_cnt;
    logic [23:0] startup_cnt;
    logic [9:0]  blank_cnt;
    logic [15:0] oc_cnt;
    logic [7:0][16:0] short_cnt;
    logic        ack;
    logic [31:0] rdata;
    analog_ctl_t ctl;
    freq_sel_t   freq;
  } state_t;

  state_t s_q;
  state_t s_d;

  function automatic logic [23:0] inc24(input logic [23:0] v);
    inc24 = (v == 24'hFF_FFFF) ? v : v + 24'h00_0001;
  endfunction : inc24

  comp_t      c;
  logic [7:0] active;
  logic       sel;

  always_comb begin
    s_d    = s_q;
    c      = s_q.sync2;
    active = ~s_q.excluded & ~s_q.tied_off;
    sel    = (avs_read | avs_write) & ~s_q.ack;

    // ----------------------------------------------------------------
    // synchronisers
    // ----------------------------------------------------------------
    // two-stage sync
    s_d.sync1  = comp_raw;
    s_d.sync2  = s_q.sync1;
    s_d.pwm_s1 = internal_dimming_pwm;
    s_d.pwm_s2 = s_q.pwm_s1;
    s_d.good_prev = c.supply_good;

    // ----------------------------------------------------------------
    // bus slave: one wait cycle, then answer
    // ----------------------------------------------------------------
    s_d.ack = sel;
    if (sel && avs_read) begin
      case (avs_address)
        ADDR_CONTROL: s_d.rdata = {24'h00_0000, 7'h00, s_q.control[CTRL_EN_BIT]};
        ADDR_STATUS:  s_d.rdata = {24'h00_0000, s_q.status};
        ADDR_STRINGS: s_d.rdata = {8'h00, 5'h00, s_q.st, s_q.tied_off, s_q.excluded};
        default:      s_d.rdata = 32'h0000_0000;
      endcase
    end
    if (sel && avs_write && avs_address == ADDR_CONTROL && avs_byteenable[0]) begin
      s_d.control = {7'h00, avs_writedata[CTRL_EN_BIT]};
    end

    // ----------------------------------------------------------------
    // power-on scan
    // ----------------------------------------------------------------
    // one scan only
    if (!s_q.scanned && c.supply_good) begin
      s_d.scanned  = 1'b1;
      s_d.tied_off = c.fb_above_unused;
    end

    if (switch_frequency_select_pin_high) begin
      s_d.freq = FREQ_1000K;
    end else if (switch_frequency_select_pin_low) begin
      s_d.freq = FREQ_500K;
    end else begin
      s_d.freq = FREQ_750K;
    end

    // ----------------------------------------------------------------
    // sequencer
    // ----------------------------------------------------------------
    s_d.phase_cnt   = inc24(s_q.phase_cnt);
    s_d.startup_cnt = inc24(s_q.startup_cnt);
    case (s_q.st)
      ST_RESET: begin
        if (c.uvlo_ok && s_q.control[CTRL_EN_BIT] && s_q.scanned) begin
          s_d.status      = STATUS_RST;
          s_d.excluded    = 8'h00;
          s_d.st          = ST_DIODE;
          s_d.phase_cnt   = 24'h00_0000;
          s_d.startup_cnt = 24'h00_0000;
        end
      end
      ST_DIODE: begin
        if (c.ov_diode_low) begin
          s_d.status[STAT_DIODE_BIT] = 1'b1;
          s_d.st = ST_SHUTDOWN;
        end else begin
          s_d.st = ST_DIAG1;
          s_d.phase_cnt = 24'h00_0000;
        end
      end
      ST_DIAG1: begin
        if (s_q.phase_cnt >= 24'(DIAG_LIMIT - 1)) begin
          s_d.excluded = s_q.excluded | (c.fb_above_short & ~s_q.tied_off);
          s_d.tied_off = s_q.tied_off | (c.fb_above_unused & ~c.fb_above_short);
          s_d.status[STAT_SHORT_BIT] = s_q.status[STAT_SHORT_BIT] |
                                       (|(c.fb_above_short & ~s_q.tied_off));
          s_d.st = ST_DIAG2;
          s_d.phase_cnt = 24'h00_0000;
        end
      end
      ST_DIAG2: begin
        if (s_q.phase_cnt >= 24'(DIAG_LIMIT - 1)) begin
          if (|(c.fb_below_gnd & active)) begin
            s_d.status[STAT_GND_BIT] = 1'b1;
            s_d.st = ST_SHUTDOWN;
          end else begin
            s_d.st = ST_SOFT;
            s_d.phase_cnt = 24'h00_0000;
          end
        end
      end
      ST_SOFT: begin
        if (s_q.phase_cnt >= 24'(SOFT_LIMIT - 1) ||
            s_q.startup_cnt >= 24'(STARTUP_LIMIT - 1)) begin
          s_d.st = ST_RUN;
        end
      end
      ST_RUN: begin
        s_d.open_seen = c.fb_below_open & active & {8{s_q.pwm_s2}};
        if (|s_d.open_seen) begin
          s_d.excluded = s_q.excluded | s_d.open_seen;
          s_d.status[STAT_OPEN_BIT] = 1'b1;
        end
        for (int i = 0; i < NUM_STRINGS; i++) begin
          if (c.fb_above_short[i] && active[i] && s_q.blank_cnt >= 10'(BLANK_CYC)) begin
            s_d.short_cnt[i] = s_q.short_cnt[i] + 17'h0_0001;
            if (s_q.short_cnt[i] >= 17'(SHORT_LIMIT - 1)) begin
              s_d.excluded[i] = 1'b1;
              s_d.status[STAT_SHORT_BIT] = 1'b1;
            end
          end else begin
            s_d.short_cnt[i] = 17'h0_0000;
          end
        end
        if ((active & ~s_d.excluded) == 8'h00) begin
          s_d.st = ST_SHUTDOWN;
        end
      end
      ST_SHUTDOWN: begin
        if (!s_q.control[CTRL_EN_BIT]) begin
          s_d.st = ST_RESET;
        end
      end
      default: s_d.st = ST_RESET;
    endcase

    // blanking counter, held at zero outside run or while dimmed off
    if (s_q.st != ST_RUN || !s_q.pwm_s2) begin
      s_d.blank_cnt = 10'h000;
    end else if (s_q.blank_cnt < 10'(BLANK_CYC)) begin
      s_d.blank_cnt = s_q.blank_cnt + 10'h001;
    end

    if (c.current_limit && (s_q.st == ST_SOFT || s_q.st == ST_RUN)) begin
      s_d.oc_cnt = s_q.oc_cnt + 16'h0001;
      if (s_q.oc_cnt >= 16'(OC_CYC - 1)) begin
        s_d.status[STAT_OC_BIT] = 1'b1;
        s_d.st = ST_SHUTDOWN;
      end
    end else begin
      s_d.oc_cnt = 16'h0000;
    end

    // enable low forces shutdown
    // shutdown itself must stay free to fall back to reset once enable is low
    if (!s_q.control[CTRL_EN_BIT] && s_q.st != ST_RESET && s_q.st != ST_SHUTDOWN) begin
      s_d.st = ST_SHUTDOWN;
    end
    if (!c.uvlo_ok && s_q.st != ST_SHUTDOWN) begin
      s_d.st = ST_RESET;
    end

    // ----------------------------------------------------------------
    // analog controls, registered
    // ----------------------------------------------------------------
    // shutdown turns everything off except lvc_select, which keeps the enabled-string mask
    s_d.ctl.regulator_en   = s_d.st != ST_SHUTDOWN && s_d.st != ST_RESET;
    s_d.ctl.boost_en       = s_d.st == ST_SOFT || s_d.st == ST_RUN;
    s_d.ctl.switch_en      = s_d.ctl.boost_en && !c.ov_above;
    s_d.ctl.soft_start     = s_d.st == ST_SOFT;
    s_d.ctl.diag_discharge = s_d.st == ST_DIAG1;
    s_d.ctl.diag_precharge = s_d.st == ST_DIAG2;
    s_d.ctl.lvc_select     = ~s_d.excluded & ~s_d.tied_off;
    // common pwm gate, one cycle latency
    s_d.ctl.source_on      = s_d.ctl.boost_en ?
                             (s_d.ctl.lvc_select & {8{s_q.pwm_s2}}) : 8'h00;

    if (c.supply_good && !s_q.good_prev) begin
      s_d.status  = STATUS_RST;
      s_d.control = CONTROL_RST;
      s_d.st      = ST_RESET;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (srst) begin
      s_q <= '0;
    end else if (clk_en) begin
      s_q <= s_d;
    end
  end

  assign avs_waitrequest = (avs_read | avs_write) & ~s_q.ack;
  assign avs_readdata    = s_q.rdata;
  assign analog_ctl      = s_q.ctl;
  assign switch_freq     = s_q.freq;
  assign seq_state       = s_q.st;

endmodule : led_string_startup_fault_supervisor

// file: verif/led_array_model.sv
`timescale 1ns/1ps
module led_array_model (
  // controls from the supervisor
  input  wire led_sup_pkg::analog_ctl_t ctl,
  // fault knobs: string masks and {supply, uvlo, ov, diode, limit}
  input  wire logic [7:0]               open_m,
  input  wire logic [7:0]               short_m,
  input  wire logic [7:0]               tied_m,
  input  wire logic [7:0]               gnd_m,
  input  wire logic [4:0]               misc,
  // comparator outputs
  output led_sup_pkg::comp_t            comp
);
  import led_sup_pkg::*;

  always_comb begin
    comp.supply_good     = misc[4];
    comp.uvlo_ok         = misc[3];
    comp.ov_above        = misc[2];
    comp.ov_diode_low    = misc[1];
    // the limit trips only while the switch really runs
    comp.current_limit   = misc[0] & ctl.switch_en;
    comp.fb_above_short  = short_m;
    comp.fb_above_unused = short_m | tied_m;
    comp.fb_below_gnd    = gnd_m;
    // open collapse; a grounded node also reads as open
    comp.fb_below_open   = open_m | gnd_m;
  end
endmodule : led_array_model

// file: verif/led_sup_asserts.sv
`timescale 1ns/1ps
module led_sup_asserts #(
  parameter int STARTUP_LIMIT = led_sup_pkg::STARTUP_CYC
) (
  // clock and reset
  input wire logic                       clk_sys,
  input wire logic                       srst,
  input wire logic                       clk_en,
  // bus
  input wire logic [3:0]                 avs_address,
  input wire logic                       avs_read,
  input wire logic                       avs_write,
  input wire logic [31:0]                avs_writedata,
  input wire logic [3:0]                 avs_byteenable,
  input wire logic                       avs_waitrequest,
  // analog side
  input wire led_sup_pkg::comp_t         comp_raw,
  input wire logic                       switch_frequency_select_pin_low,
  input wire logic                       switch_frequency_select_pin_high,
  input wire logic                       internal_dimming_pwm,
  input wire led_sup_pkg::analog_ctl_t   analog_ctl,
  input wire led_sup_pkg::freq_sel_t     switch_freq,
  input wire led_sup_pkg::seq_state_t    seq_state
);
  import led_sup_pkg::*;
  logic [31:0] seq_cnt_q;
  logic [31:0] seq_cnt_d;

  // counts only bounded phases; a failed diode check parks in shutdown
  always_comb begin
    seq_cnt_d = seq_cnt_q + {31'h0, clk_en};
    if (!(seq_state inside {ST_DIAG1, ST_DIAG2, ST_SOFT})) seq_cnt_d = 32'h0;
  end
  always_ff @(posedge clk_sys) begin
    if (srst) seq_cnt_q <= 32'h0;
    else seq_cnt_q <= seq_cnt_d;
  end

  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (srst);

  property p_wait_one;
    (avs_read || avs_write) && avs_waitrequest && clk_en |=> !avs_waitrequest;
  endproperty
  a_wait_one: assert property (p_wait_one) else $error("bus answer late");
  property p_uvlo_gate;
    !comp_raw.uvlo_ok [*6] |-> !analog_ctl.boost_en;
  endproperty
  a_uvlo_gate: assert property (p_uvlo_gate) else $error("boost on in undervoltage");
  property p_ov_off;
    comp_raw.ov_above [*5] |-> !analog_ctl.switch_en;
  endproperty
  a_ov_off: assert property (p_ov_off) else $error("switch on above ov");
  property p_order;
    $changed(seq_state) |-> (seq_state != ST_DIAG2 || $past(seq_state) == ST_DIAG1)
      && (seq_state != ST_SOFT || $past(seq_state) == ST_DIAG2)
      && (seq_state != ST_RUN || $past(seq_state) == ST_SOFT);
  endproperty
  a_order: assert property (p_order) else $error("sequence order broken");
  property p_boost_phase;
    analog_ctl.boost_en |-> seq_state inside {ST_SOFT, ST_RUN}
      || $past(seq_state) inside {ST_SOFT, ST_RUN};
  endproperty
  a_boost_phase: assert property (p_boost_phase) else $error("boost outside run");
  property p_enable_off;
    avs_write && !avs_waitrequest && avs_address == ADDR_CONTROL && avs_byteenable[0]
      && !avs_writedata[0] |-> ##[1:4] !analog_ctl.boost_en;
  endproperty
  a_enable_off: assert property (p_enable_off) else $error("enable clear ignored");
  property p_pwm_gate;
    !internal_dimming_pwm [*5] |-> analog_ctl.source_on == 8'h00;
  endproperty
  a_pwm_gate: assert property (p_pwm_gate) else $error("source on with pwm low");
  property p_shutdown_off;
    seq_state == ST_SHUTDOWN [*2] |-> !analog_ctl.regulator_en && !analog_ctl.boost_en;
  endproperty
  a_shutdown_off: assert property (p_shutdown_off) else $error("shutdown left on");
  property p_startup_time;
    seq_cnt_q <= STARTUP_LIMIT;
  endproperty
  a_startup_time: assert property (p_startup_time) else $error("startup too long");
  property p_freq;
    $stable({switch_frequency_select_pin_low, switch_frequency_select_pin_high}) [*6] |->
      switch_freq == (switch_frequency_select_pin_low ? FREQ_500K :
      switch_frequency_select_pin_high ? FREQ_1000K : FREQ_750K);
  endproperty
  a_freq: assert property (p_freq) else $error("frequency decode wrong");
  property p_soft_keep;
    seq_state == ST_SOFT && $past(seq_state) == ST_SOFT |-> $stable(analog_ctl.lvc_select);
  endproperty
  a_soft_keep: assert property (p_soft_keep) else $error("string dropped in soft-start");
  c_run: cover property (seq_state == ST_RUN);
  c_shut: cover property (seq_state == ST_SHUTDOWN);
  c_part: cover property (analog_ctl.source_on != 8'h00 && analog_ctl.source_on != 8'hFF);
endmodule : led_sup_asserts

bind led_string_startup_fault_supervisor led_sup_asserts #(
  .STARTUP_LIMIT(STARTUP_LIMIT)
) led_sup_asserts_i (
  .clk_sys, .srst, .clk_en, .avs_address, .avs_read, .avs_write, .avs_writedata,
  .avs_byteenable, .avs_waitrequest, .comp_raw, .switch_frequency_select_pin_low,
  .switch_frequency_select_pin_high, .internal_dimming_pwm, .analog_ctl, .switch_freq,
  .seq_state
);

// file: verif/led_string_startup_fault_supervisor_test.sv
`timescale 1ns/1ps
module led_string_startup_fault_supervisor_test;
  import led_sup_pkg::*;
  logic clk_sys = 0, srst = 1, rd_q = 0, wr_q = 0, pwm = 0, f_lo = 1, f_hi = 0, ce = 1;
  logic [3:0] addr = 4'h0, be = 4'hF;
  logic [31:0] wdata = 32'h0000_0000, avs_readdata;
  logic avs_waitrequest;
  logic [7:0] open_m = 8'h00, short_m = 8'h00, tied_m = 8'h00, gnd_m = 8'h00, on_m;
  logic [4:0] misc = 5'h00;
  logic [63:0] cur, exp_q[$];
  comp_t comp_raw;
  analog_ctl_t analog_ctl;
  freq_sel_t switch_freq, ft[3] = '{FREQ_500K, FREQ_750K, FREQ_1000K};
  seq_state_t seq_state;
  int bad_count = 0, checks_done = 0, cyc = 0, t, o, s, n;

  always #25 clk_sys = ~clk_sys;

  led_string_startup_fault_supervisor #(.STARTUP_LIMIT(200), .SHORT_LIMIT(30),
    .DIAG_LIMIT(20), .SOFT_LIMIT(40)) led_string_startup_fault_supervisor_i (
    .clk_sys(clk_sys), .srst(srst), .clk_en(ce), .avs_address(addr), .avs_read(rd_q),
    .avs_write(wr_q), .avs_writedata(wdata), .avs_byteenable(be),
    .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest), .comp_raw(comp_raw),
    .switch_frequency_select_pin_low(f_lo), .switch_frequency_select_pin_high(f_hi),
    .internal_dimming_pwm(pwm), .analog_ctl(analog_ctl), .switch_freq(switch_freq),
    .seq_state(seq_state));
  led_array_model led_array_model_i (.ctl(analog_ctl), .open_m(open_m), .short_m(short_m),
    .tied_m(tied_m), .gnd_m(gnd_m), .misc(misc), .comp(comp_raw));

  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string m);
    checks_done++;
    if (got !== exp) begin
      bad_count++;
      $display("[ERR] %0t %s got %h exp %h", $time, m, got, exp);
    end
  endtask : chk
  task automatic bus(input logic w, input logic [3:0] a, input logic [31:0] d);
    addr <= a; wdata <= d; rd_q <= !w; wr_q <= w;
    // only the bench timeout ends a wait that never gets its answer
    do begin @(posedge clk_sys); end while (avs_waitrequest !== 1'b0);
    rd_q <= 1'b0; wr_q <= 1'b0;
    @(posedge clk_sys);
  endtask : bus
  task automatic rd(input logic [3:0] a, input logic [31:0] e, input logic [31:0] m);
    exp_q.push_back({m, e});
    bus(1'b0, a, 32'h0000_0000);
  endtask : rd
  task automatic waitc(input int k);
    repeat (k) @(posedge clk_sys);
  endtask : waitc
  task automatic wait_st(input seq_state_t st, input int lim);
    n = 0;
    while (seq_state !== st && n < lim) begin @(posedge clk_sys); n++; end
    chk(seq_state, st, "state");
  endtask : wait_st
  task automatic restart();
    bus(1'b1, ADDR_CONTROL, 32'h0000_0000); waitc(4); bus(1'b1, ADDR_CONTROL, 32'h0000_0001);
  endtask : restart
  task automatic test_done();
    $display("checks %0d mismatches %0d", checks_done, bad_count);
    if (bad_count == 0 && checks_done > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask : test_done

  // ----------------------------------------------------------------
  // read monitor and hang guard
  // ----------------------------------------------------------------
  always @(posedge clk_sys) begin
    if (rd_q && avs_waitrequest === 1'b0) begin
      cur = exp_q.pop_front();
      chk(avs_readdata & cur[63:32], cur[31:0], "read");
    end
    cyc++;
    if (cyc == 20000) begin bad_count++; $display("[ERR] %0t timeout", $time); test_done(); end
  end

  initial begin
    n = $urandom(32'h8f32);
    t = $urandom % 8; o = (t + 1 + $urandom % 7) % 8; s = (o + 1) % 8;
    if (s == t) s = (s + 1) % 8;
    waitc(16); srst <= 1'b0;
    bus(1'b1, ADDR_CONTROL, 32'h0000_0001);
    misc <= 5'h18; waitc(8);
    rd(ADDR_CONTROL, 32'h0, 32'hFF);
    rd(ADDR_STATUS, 32'h0, 32'hFF);
    bus(1'b1, 4'h0, 32'hFFFF_FFFF); rd(4'h0, 32'h0, 32'hFFFF_FFFF);
    chk(seq_state, ST_RESET, "idle");
    for (int i = 0; i < 3; i++) begin
      f_lo <= (i == 0); f_hi <= (i == 2); waitc(8);
      chk(switch_freq, ft[i], "freq");
    end
    $display("test power_on done");
    misc <= 5'h10; tied_m <= 8'h1 << t; bus(1'b1, ADDR_CONTROL, 32'h0000_0001); waitc(20);
    chk(analog_ctl.boost_en, 0, "uvlo");
    rd(ADDR_CONTROL, 32'h1, 32'h1);
    be <= 4'hE; bus(1'b1, ADDR_CONTROL, 32'h0000_0000);
    be <= 4'hF; rd(ADDR_CONTROL, 32'h1, 32'h1);
    misc <= 5'h18;
    wait_st(ST_DIAG1, 20); ce <= 1'b0; waitc(40);
    chk(seq_state, ST_DIAG1, "freeze"); ce <= 1'b1;
    wait_st(ST_SOFT, 100); wait_st(ST_RUN, 150);
    on_m = ~(8'h1 << t); tied_m <= (8'h1 << t) | (8'h1 << s); pwm <= 1'b1; waitc(8);
    chk(analog_ctl.source_on, on_m, "sources");
    chk(analog_ctl.lvc_select[t], 0, "lvc");
    rd(ADDR_STRINGS, (32'h1 << (8 + t)) | (32'(ST_RUN) << 16), 32'h0007_FF00);
    misc <= 5'h1C; waitc(6); chk(analog_ctl.switch_en, 0, "ov");
    misc <= 5'h18; waitc(6); chk(analog_ctl.switch_en, 1, "ov off");
    pwm <= 1'b0; waitc(6); chk(analog_ctl.source_on, 0, "pwm");
    pwm <= 1'b1; $display("test startup done");
    open_m <= 8'h1 << o; waitc(40); on_m[o] = 1'b0;
    chk(analog_ctl.source_on, on_m, "open");
    chk(analog_ctl.boost_en, 1, "open run");
    rd(ADDR_STATUS, 32'h10, 32'h30);
    short_m <= 8'h1 << s; waitc(600); on_m[s] = 1'b0;
    chk(analog_ctl.source_on, on_m, "short");
    rd(ADDR_STATUS, 32'h30, 32'h30);
    open_m <= 8'hFF; waitc(40); chk(analog_ctl.boost_en, 0, "all open");
    bus(1'b1, ADDR_CONTROL, 32'h0000_0000); waitc(8);
    chk(analog_ctl.regulator_en, 0, "off");
    rd(ADDR_STATUS, 32'h30, 32'h30);
    open_m <= 8'h00; bus(1'b1, ADDR_CONTROL, 32'h0000_0001);
    wait_st(ST_RUN, 200); rd(ADDR_STATUS, 32'h20, 32'hF8);
    on_m = ~((8'h1 << t) | (8'h1 << s));
    chk(analog_ctl.source_on, on_m, "diag short");
    $display("test faults done");
    misc <= 5'h19; waitc(2700);
    chk(seq_state, ST_SHUTDOWN, "oc");
    chk(analog_ctl.regulator_en, 0, "oc reg");
    rd(ADDR_STATUS, 32'h1 << STAT_OC_BIT, 32'h1 << STAT_OC_BIT);
    misc <= 5'h1A; restart(); waitc(100);
    chk(analog_ctl.boost_en, 0, "diode");
    rd(ADDR_STATUS, 32'h1 << STAT_DIODE_BIT, 32'h1 << STAT_DIODE_BIT);
    misc <= 5'h18; gnd_m <= 8'h1 << o; restart(); waitc(120);
    chk(analog_ctl.regulator_en, 0, "gnd");
    rd(ADDR_STATUS, 32'h1 << STAT_GND_BIT, 32'h1 << STAT_GND_BIT);
    $display("test critical done");
    test_done();
  end
endmodule : led_string_startup_fault_supervisor_test
